// *** hdl/fdcm_consts.svh ***
// constants for the flag-mode fifo: sizes, thresholds, offsets, register map
`ifndef FDCM_CONSTS_SVH
`define FDCM_CONSTS_SVH
`define FDCM_DATA_W 18
`define FDCM_PTR_W 17
`define FDCM_CNT_W 18
`define FDCM_OFS_W 17
`define FDCM_DEPTH 18'h20000
`define FDCM_HALF 18'h10000
`define FDCM_ONE 18'h00001
`define FDCM_OFS_SERIAL 17'h003FF
`define FDCM_OFS_PARALLEL 17'h0007F
`define FDCM_FT_WAIT 2'h2
`define FDCM_ADDR_W 5
`define FDCM_REG_EOFS 5'h00
`define FDCM_REG_FOFS 5'h04
`define FDCM_REG_STAT 5'h08
`define FDCM_REG_LEVEL 5'h0C
`define FDCM_RESP_OKAY 2'h0
`define FDCM_RESP_DECERR 2'h3
`endif

// *** hdl/fdcm_pkg.sv ***
// types for the flag-mode fifo: phase enum and the packed state record
`include "fdcm_consts.svh"
package fdcm_pkg;
	typedef enum logic [1:0] {
		FDCM_PH_RESET = 2'h0,
		FDCM_PH_RUN = 2'h1
	} fdcm_phase_t;

	typedef struct packed {
		fdcm_phase_t phase;
		logic fall_through_mode;
		logic serial_ld;
		logic [`FDCM_OFS_W-1:0] e_ofs;
		logic [`FDCM_OFS_W-1:0] f_ofs;
		logic [`FDCM_PTR_W-1:0] wptr;
		logic [`FDCM_PTR_W-1:0] rptr;
		logic [`FDCM_CNT_W-1:0] cnt;
		logic ov;
		logic [1:0] wait_cnt;
		logic [`FDCM_DATA_W-1:0] dout;
		logic [1:0] ef_sr;
		logic [1:0] ffn_sr;
		logic [2:0] orn_sr;
		logic [1:0] ir_sr;
		logic pae_n;
		logic hf_n;
		logic paf_n;
		logic aw_held;
		logic [`FDCM_ADDR_W-1:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} fdcm_state_t;
endpackage : fdcm_pkg

// *** hdl/fdcm_mem.sv ***
// word storage of the fifo: one write port, one indexed read port
`timescale 1ns/1ns
`include "fdcm_consts.svh"
module fdcm_mem (
	input wire logic i_sys_clk,
	input wire logic i_wr_en,
	input wire logic [`FDCM_PTR_W-1:0] i_wr_addr,
	input wire logic [`FDCM_DATA_W-1:0] i_wr_data,
	input wire logic [`FDCM_PTR_W-1:0] i_rd_addr,
	output logic [`FDCM_DATA_W-1:0] o_rd_data
);
	logic [`FDCM_DATA_W-1:0] mem_ff [0:(1<<`FDCM_PTR_W)-1];

	// store a word at the write index
	always_ff @(posedge i_sys_clk) begin
		if (i_wr_en) begin
			mem_ff[i_wr_addr] <= i_wr_data;
		end
	end

	// read index is looked up without a clock; the top registers it
	assign o_rd_data = mem_ff[i_rd_addr];
endmodule : fdcm_mem

// *** hdl/fdcm_top.sv ***
// flag-mode fifo top: storage control, flags, offsets, axi4-lite registers
// Function
// - Strap at reset picks standard (low) or fall-through (high) timing.
// - Fall-through: first word reaches outputs after three read edges.
// - Word stored on each clock edge with write enable low, unless storage holds 131,072 words.
// - Standard: empty flag rises once first word is written.
// - Standard: almost-empty rises at empty offset plus one words.
// - Standard: half-full falls at word 65,537.
// - Standard: almost-full falls at 131,072 minus full offset words.
// - Standard: full flag falls at 131,072 words; first read raises it.
// - Standard drain: almost-empty falls with empty offset words left.
// - Empty indication active after last read; reads ignored while empty.
// - Standard: empty and full flags pass two register stages.
// - Fall-through: output-ready falls when first word is valid.
// - Fall-through: almost-empty rises at empty offset plus two words.
// - Fall-through: half-full falls at word 65,538.
// - Fall-through: almost-full falls at 131,073 minus full offset words.
// - Fall-through: input-ready rises at 131,073 words; first read drops it.
// - Fall-through drain: almost-empty low at offset plus one; ready after.
// - Fall-through: output-ready three stages, input-ready two stages.
// - Load strap high: serial loading, both offsets preset to 1,023.
// - Load strap low: parallel loading, both offsets preset to 127.
// - Offsets readable over the bus with either load strap; rewritable any time after reset.
`timescale 1ns/1ns
`include "fdcm_consts.svh"
module fdcm_top (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_fall_through_select_serial_in,
	input wire logic i_offset_load_n,
	input wire logic i_wr_en_n,
	input wire logic [`FDCM_DATA_W-1:0] i_wr_data,
	input wire logic i_rd_en_n,
	output logic [`FDCM_DATA_W-1:0] o_read_data_out,
	output logic o_empty_flag_n,
	output logic o_full_flag_n,
	output logic o_output_ready_n,
	output logic o_input_ready_n,
	output logic o_almost_empty_flag_n,
	output logic o_almost_full_flag_n,
	output logic o_half_full_flag_n,
	input wire logic [`FDCM_ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [`FDCM_ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready
);
	fdcm_pkg::fdcm_state_t st, nxt_st;
	logic [`FDCM_DATA_W-1:0] mem_rd;
	logic [`FDCM_CNT_W-1:0] total;
	logic [`FDCM_CNT_W-1:0] lvl;
	logic run;
	logic mem_full;
	logic wr_ok;
	logic rd_std;
	logic rd_ft;
	logic load;
	logic pop;
	logic [31:0] e_merged;
	logic [31:0] f_merged;

	// true for the four word-aligned register offsets
	function automatic logic fdcm_mapped(
		input logic [`FDCM_ADDR_W-1:0] a);
		fdcm_mapped = (a == `FDCM_REG_EOFS) || (a == `FDCM_REG_FOFS) ||
			(a == `FDCM_REG_STAT) || (a == `FDCM_REG_LEVEL);
	endfunction : fdcm_mapped

	// byte-lane merge of a bus write into an existing word
	function automatic logic [31:0] fdcm_merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		fdcm_merge = r;
	endfunction : fdcm_merge

	fdcm_mem u_mem (
		.i_sys_clk(i_sys_clk),
		.i_wr_en(wr_ok),
		.i_wr_addr(st.wptr),
		.i_wr_data(i_wr_data),
		.i_rd_addr(st.rptr),
		.o_rd_data(mem_rd)
	);

	// words held, counting the fall-through output register
	assign total = st.cnt + {17'h0, st.ov};
	// fall-through levels shift by one so both modes share thresholds
	assign lvl = (st.fall_through_mode && total != 18'h0) ? total - `FDCM_ONE : total;
	assign run = st.phase == fdcm_pkg::FDCM_PH_RUN;
	assign mem_full = st.cnt == `FDCM_DEPTH;
	// writes are gated by the live count so the flag pipeline cannot overrun
	assign wr_ok = run && !i_wr_en_n && !mem_full;
	assign rd_std = run && !st.fall_through_mode && !i_rd_en_n && st.cnt != 18'h0;
	assign rd_ft = run && st.fall_through_mode && !i_rd_en_n && st.ov;
	// prefetch into the output register on the third edge or on a read
	assign load = st.fall_through_mode && st.cnt != 18'h0 &&
		(rd_ft || (!st.ov && st.wait_cnt == `FDCM_FT_WAIT));
	assign pop = rd_std || load;
	// offsets merged with the held bus word, cut back to offset width below
	assign e_merged = fdcm_merge({15'h0, st.e_ofs}, st.wdata, st.wstrb);
	assign f_merged = fdcm_merge({15'h0, st.f_ofs}, st.wdata, st.wstrb);

	// next state of the whole block
	always_comb begin
		nxt_st = st;
		case (st.phase)
			fdcm_pkg::FDCM_PH_RESET: begin
				nxt_st.fall_through_mode = i_fall_through_select_serial_in;
				nxt_st.serial_ld = i_offset_load_n;
				if (i_offset_load_n) begin
					nxt_st.e_ofs = `FDCM_OFS_SERIAL;
					nxt_st.f_ofs = `FDCM_OFS_SERIAL;
				end else begin
					nxt_st.e_ofs = `FDCM_OFS_PARALLEL;
					nxt_st.f_ofs = `FDCM_OFS_PARALLEL;
				end
				nxt_st.phase = fdcm_pkg::FDCM_PH_RUN;
			end
			fdcm_pkg::FDCM_PH_RUN: begin
				nxt_st.phase = fdcm_pkg::FDCM_PH_RUN;
			end
			default: begin
				nxt_st.phase = fdcm_pkg::FDCM_PH_RESET;
			end
		endcase

		// pointers, count and output word
		if (wr_ok) begin
			nxt_st.wptr = st.wptr + 17'h1;
		end
		nxt_st.cnt = st.cnt + {17'h0, wr_ok} - {17'h0, pop};
		if (pop) begin
			nxt_st.rptr = st.rptr + 17'h1;
			nxt_st.dout = mem_rd;
		end
		if (load) begin
			nxt_st.ov = 1'b1;
		end else if (rd_ft) begin
			nxt_st.ov = 1'b0;
		end
		if (st.ov || st.cnt == 18'h0 || load) begin
			nxt_st.wait_cnt = 2'h0;
		end else begin
			nxt_st.wait_cnt = st.wait_cnt + 2'h1;
		end

		// empty/full pipelines; a read that empties the buffer or leaves full sets them at once
		if (!st.fall_through_mode) begin
			nxt_st.ef_sr = {st.ef_sr[0], st.cnt != 18'h0};
			if (rd_std && st.cnt == `FDCM_ONE && !wr_ok) begin
				nxt_st.ef_sr = 2'b00;
			end
			nxt_st.ffn_sr = {st.ffn_sr[0], !mem_full};
			if (rd_std && mem_full) begin
				nxt_st.ffn_sr = 2'b11;
			end
			nxt_st.orn_sr = 3'b111;
			nxt_st.ir_sr = 2'b11;
		end else begin
			nxt_st.orn_sr = {st.orn_sr[1:0], total == 18'h0};
			if (rd_ft && st.cnt == 18'h0) begin
				nxt_st.orn_sr = 3'b111;
			end
			nxt_st.ir_sr = {st.ir_sr[0], mem_full && st.ov};
			if (rd_ft && mem_full) begin
				nxt_st.ir_sr = 2'b00;
			end
			nxt_st.ef_sr = 2'b11;
			nxt_st.ffn_sr = 2'b11;
		end

		// programmable and half flags from the shared level
		nxt_st.pae_n = lvl > {1'b0, st.e_ofs};
		nxt_st.hf_n = !(lvl > `FDCM_HALF);
		nxt_st.paf_n = !(lvl >= `FDCM_DEPTH - {1'b0, st.f_ofs});

		// bus write: address and data taken in either order
		if (i_awvalid && st.awready) begin
			nxt_st.aw_held = 1'b1;
			nxt_st.awaddr = i_awaddr;
			nxt_st.awready = 1'b0;
		end
		if (i_wvalid && st.wready) begin
			nxt_st.w_held = 1'b1;
			nxt_st.wdata = i_wdata;
			nxt_st.wstrb = i_wstrb;
			nxt_st.wready = 1'b0;
		end
		if (st.aw_held && st.w_held && !st.bvalid) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = fdcm_mapped(st.awaddr) ?
				`FDCM_RESP_OKAY : `FDCM_RESP_DECERR;
			if (st.awaddr == `FDCM_REG_EOFS) begin
				nxt_st.e_ofs = e_merged[`FDCM_OFS_W-1:0];
			end
			if (st.awaddr == `FDCM_REG_FOFS) begin
				nxt_st.f_ofs = f_merged[`FDCM_OFS_W-1:0];
			end
		end
		if (st.bvalid && i_bready) begin
			nxt_st.bvalid = 1'b0;
			nxt_st.awready = 1'b1;
			nxt_st.wready = 1'b1;
		end

		// bus read: one-cycle answer, unmapped reads zero with decerr
		if (i_arvalid && st.arready) begin
			nxt_st.arready = 1'b0;
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = fdcm_mapped(i_araddr) ?
				`FDCM_RESP_OKAY : `FDCM_RESP_DECERR;
			case (i_araddr)
				`FDCM_REG_EOFS: nxt_st.rdata = {15'h0, st.e_ofs};
				`FDCM_REG_FOFS: nxt_st.rdata = {15'h0, st.f_ofs};
				`FDCM_REG_STAT: nxt_st.rdata = {29'h0, run, st.serial_ld,
					st.fall_through_mode};
				`FDCM_REG_LEVEL: nxt_st.rdata = {14'h0, total};
				default: nxt_st.rdata = 32'h0;
			endcase
		end
		if (st.rvalid && i_rready) begin
			nxt_st.rvalid = 1'b0;
			nxt_st.arready = 1'b1;
		end
	end

	// state register; reset shows an empty standard-mode buffer
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st <= '0;
			st.ffn_sr <= 2'b11;
			st.orn_sr <= 3'b111;
			st.ir_sr <= 2'b11;
			st.hf_n <= 1'b1;
			st.paf_n <= 1'b1;
			st.awready <= 1'b1;
			st.wready <= 1'b1;
			st.arready <= 1'b1;
		end else begin
			st <= nxt_st;
		end
	end

	// outputs straight from the state record
	assign o_read_data_out = st.dout;
	assign o_empty_flag_n = st.ef_sr[1];
	assign o_full_flag_n = st.ffn_sr[1];
	assign o_output_ready_n = st.orn_sr[2];
	assign o_input_ready_n = st.ir_sr[1];
	assign o_almost_empty_flag_n = st.pae_n;
	assign o_almost_full_flag_n = st.paf_n;
	assign o_half_full_flag_n = st.hf_n;
	assign o_awready = st.awready;
	assign o_wready = st.wready;
	assign o_bresp = st.bresp;
	assign o_bvalid = st.bvalid;
	assign o_arready = st.arready;
	assign o_rdata = st.rdata;
	assign o_rresp = st.rresp;
	assign o_rvalid = st.rvalid;

	// checks on strap capture, fill count, flag timing, thresholds and offset presets
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	property p_mode_strap;
		st.phase == fdcm_pkg::FDCM_PH_RESET |=>
			st.fall_through_mode == $past(i_fall_through_select_serial_in);
	endproperty
	a_mode_strap: assert property (p_mode_strap)
		else $error("mode strap not captured");

	property p_std_ef_rise;
		run && !st.fall_through_mode && st.cnt == 18'h0 && wr_ok ##1 !rd_std [*2]
			|=> o_empty_flag_n;
	endproperty
	a_std_ef_rise: assert property (p_std_ef_rise)
		else $error("empty flag not high two stages after first write");

	property p_ft_first_word;
		run && st.fall_through_mode && total == 18'h0 && wr_ok ##1 !wr_ok [*3] |=>
			!o_output_ready_n && o_read_data_out == $past(i_wr_data, 4);
	endproperty
	a_ft_first_word: assert property (p_ft_first_word)
		else $error("first word did not fall through on third edge");

	property p_no_overflow;
		st.cnt <= `FDCM_DEPTH;
	endproperty
	a_no_overflow: assert property (p_no_overflow)
		else $error("fill count beyond capacity");

	property p_count_write;
		wr_ok && !pop |=> st.cnt == $past(st.cnt) + `FDCM_ONE;
	endproperty
	a_count_write: assert property (p_count_write)
		else $error("write not stored");

	property p_std_pae;
		run && !st.fall_through_mode && total == {1'b0, st.e_ofs} + `FDCM_ONE |=>
			o_almost_empty_flag_n;
	endproperty
	a_std_pae: assert property (p_std_pae)
		else $error("almost-empty not high at offset plus one");

	property p_std_pae_low;
		run && !st.fall_through_mode && total == {1'b0, st.e_ofs} |=>
			!o_almost_empty_flag_n;
	endproperty
	a_std_pae_low: assert property (p_std_pae_low)
		else $error("almost-empty not low at offset");

	property p_ft_pae;
		run && st.fall_through_mode && total == {1'b0, st.e_ofs} + 18'h2 |=>
			o_almost_empty_flag_n;
	endproperty
	a_ft_pae: assert property (p_ft_pae)
		else $error("fall-through almost-empty not high at offset plus two");

	property p_std_hf;
		run && !st.fall_through_mode && total == `FDCM_HALF + `FDCM_ONE |=>
			!o_half_full_flag_n;
	endproperty
	a_std_hf: assert property (p_std_hf)
		else $error("half-full not low at 65537 words");

	property p_empty_ignore;
		!st.fall_through_mode && st.cnt == 18'h0 && !i_rd_en_n |=> $stable(st.rptr);
	endproperty
	a_empty_ignore: assert property (p_empty_ignore)
		else $error("read taken while empty");

	property p_full_release;
		run && !st.fall_through_mode && mem_full && rd_std |=> o_full_flag_n;
	endproperty
	a_full_release: assert property (p_full_release)
		else $error("full flag not released by first read");

	property p_ft_or_release;
		rd_ft && st.cnt == 18'h0 |=> o_output_ready_n;
	endproperty
	a_ft_or_release: assert property (p_ft_or_release)
		else $error("output-ready not high after last read");

	property p_serial_ofs;
		st.phase == fdcm_pkg::FDCM_PH_RESET && i_offset_load_n |=>
			st.e_ofs == `FDCM_OFS_SERIAL && st.f_ofs == `FDCM_OFS_SERIAL;
	endproperty
	a_serial_ofs: assert property (p_serial_ofs)
		else $error("serial default offsets wrong");

	property p_par_ofs;
		st.phase == fdcm_pkg::FDCM_PH_RESET && !i_offset_load_n |=>
			st.e_ofs == `FDCM_OFS_PARALLEL && st.f_ofs == `FDCM_OFS_PARALLEL;
	endproperty
	a_par_ofs: assert property (p_par_ofs)
		else $error("parallel default offsets wrong");

	// main scenarios
	c_std_fill: cover property (!st.fall_through_mode && !o_half_full_flag_n);
	c_ft_first: cover property (st.fall_through_mode && $fell(o_output_ready_n));
	c_bus_write: cover property (st.bvalid && i_bready);
	c_ft_drain: cover property (rd_ft && st.cnt == 18'h0);
endmodule : fdcm_top

// *** tb/fdcm_agent.sv ***
// partner agent: writer and reader logic facing the fifo data ports
`timescale 1ns/1ns
`include "fdcm_consts.svh"
module fdcm_agent (
	input wire logic i_sys_clk,
	output logic o_wr_en_n,
	output logic [`FDCM_DATA_W-1:0] o_wr_data,
	output logic o_rd_en_n
);
	// idle levels at time zero
	initial begin
		o_wr_en_n = 1'h1;
		o_wr_data = '0;
		o_rd_en_n = 1'h1;
	end

	// write n words counting up from base, one word per edge
	task automatic push(input int n, input logic [`FDCM_DATA_W-1:0] base);
		for (int i = 0; i < n; i++) begin
			@(posedge i_sys_clk);
			o_wr_en_n <= 1'h0;
			o_wr_data <= base + i[`FDCM_DATA_W-1:0];
		end
		@(posedge i_sys_clk);
		o_wr_en_n <= 1'h1;
		// released bus flips so stale data cannot pass as a match
		o_wr_data <= ~o_wr_data;
	endtask : push

	// request n words, enable held low for n edges in a row
	task automatic pop(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge i_sys_clk);
			o_rd_en_n <= 1'h0;
		end
		@(posedge i_sys_clk);
		o_rd_en_n <= 1'h1;
	endtask : pop
endmodule : fdcm_agent

// *** tb/tb.sv ***
// testbench of the flag-mode fifo: scenarios, bus tasks, verdict
`timescale 1ns/1ns
`include "fdcm_consts.svh"
module tb;
	logic clk, rstn, ft, ld_n, wen_n, ren_n;
	logic [`FDCM_DATA_W-1:0] wd, q;
	logic ef_n, ff_n, or_n, ir_n, ae_n, af_n, hf_n;
	logic [4:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;

	fdcm_agent u_agent (.i_sys_clk(clk), .o_wr_en_n(wen_n), .o_wr_data(wd),
		.o_rd_en_n(ren_n));
	fdcm_top u_dut (.i_sys_clk(clk), .i_rstn(rstn),
		.i_fall_through_select_serial_in(ft), .i_offset_load_n(ld_n),
		.i_wr_en_n(wen_n), .i_wr_data(wd), .i_rd_en_n(ren_n),
		.o_read_data_out(q), .o_empty_flag_n(ef_n), .o_full_flag_n(ff_n),
		.o_output_ready_n(or_n), .o_input_ready_n(ir_n),
		.o_almost_empty_flag_n(ae_n), .o_almost_full_flag_n(af_n),
		.o_half_full_flag_n(hf_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));

	// 125 MHz clock
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	// cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one bus write, both channels offered together, held until taken
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
		input logic [1:0] er, input logic [3:0] s);
		logic ar_s, w_s, b_s;
		logic [1:0] r_s;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		// readies are sampled settled, then acted on at the next edge
		do begin
			#1;
			ar_s = awready;
			w_s = wready;
			b_s = bvalid;
			r_s = bresp;
			@(posedge clk);
			if (awvalid && ar_s) awvalid <= 1'h0;
			if (wvalid && w_s) wvalid <= 1'h0;
		end while (!b_s);
		bready <= 1'h0;
		chk(r_s, er);
	endtask : axi_wr

	// one bus read, data and response taken at the answering edge
	task automatic axi_rd(input logic [4:0] a);
		logic ar_s, v_s;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			#1;
			ar_s = arready;
			v_s = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge clk);
			if (arvalid && ar_s) arvalid <= 1'h0;
		end while (!v_s);
		rready <= 1'h0;
	endtask : axi_rd

	// master reset with the two straps, then wait out the strap edges
	task automatic do_reset(input logic m, input logic l);
		rstn <= 1'h0;
		ft <= m;
		ld_n <= l;
		repeat (4) @(posedge clk);
		rstn <= 1'h1;
		repeat (4) @(posedge clk);
		#1;
	endtask : do_reset

	// parallel strap defaults, rewrite, status read and unmapped places
	task automatic t_regs();
		do_reset(1'h0, 1'h0);
		chk(ef_n, 1'h0);
		chk(ae_n, 1'h0);
		chk({ff_n, af_n, hf_n}, 3'h7);
		axi_rd(5'h00);
		chk(rd, 32'h0000007F);
		axi_rd(5'h04);
		chk(rd, 32'h0000007F);
		axi_rd(5'h08);
		chk(rd[1:0], 2'h0);
		axi_rd(5'h14);
		chk(rs, 2'h3);
		axi_wr(5'h18, 32'h00000001, 2'h3, 4'hF);
		axi_wr(5'h00, 32'h0000FF02, 2'h0, 4'h1);
		axi_wr(5'h04, 32'h0001FFFC, 2'h0, 4'hF);
		axi_rd(5'h00);
		chk(rd, 32'h00000002);
	endtask : t_regs

	// first word into empty, empty flag delay, reads past empty ignored
	task automatic t_first_word();
		u_agent.push(1, 18'h00A00);
		@(posedge clk);
		#1 chk(ef_n, 1'h0);
		@(posedge clk);
		#1 chk(ef_n, 1'h1);
		u_agent.pop(1);
		#1 chk(q, 18'h00A00);
		chk(ef_n, 1'h0);
		u_agent.pop(1);
		#1 chk(q, 18'h00A00);
	endtask : t_first_word

	// programmable flags with offsets n=2 and m=131068
	task automatic t_levels();
		u_agent.push(2, 18'h00B00);
		repeat (2) @(posedge clk);
		#1 chk(ae_n, 1'h0);
		u_agent.push(1, 18'h00B02);
		@(posedge clk);
		#1 chk(ae_n, 1'h1);
		chk(af_n, 1'h1);
		u_agent.push(1, 18'h00B03);
		@(posedge clk);
		#1 chk(af_n, 1'h0);
		axi_rd(5'h0C);
		chk(rd, 32'h00000004);
		u_agent.pop(2);
		#1 chk(q, 18'h00B01);
		@(posedge clk);
		#1 chk(ae_n, 1'h0);
		u_agent.pop(2);
		#1 chk(q, 18'h00B03);
		chk(ef_n, 1'h0);
	endtask : t_levels

	// fall-through after a second reset with the serial strap
	task automatic t_fall_through();
		do_reset(1'h1, 1'h1);
		chk({or_n, ir_n, ef_n}, 3'h5);
		axi_rd(5'h04);
		chk(rd, 32'h000003FF);
		axi_rd(5'h08);
		chk(rd[1:0], 2'h3);
		u_agent.push(1, 18'h00C00);
		repeat (2) @(posedge clk);
		#1 chk(or_n, 1'h1);
		@(posedge clk);
		#1 chk(or_n, 1'h0);
		chk(q, 18'h00C00);
		u_agent.pop(1);
		#1 chk(or_n, 1'h1);
		u_agent.pop(1);
		#1 chk(q, 18'h00C00);
	endtask : t_fall_through

	// main sequence
	initial begin
		rstn = 1'h0;
		ft = 1'h0;
		ld_n = 1'h0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
		t_regs();
		t_first_word();
		t_levels();
		t_fall_through();
		final_report();
	end
endmodule : tb
